/* rtl/etws_defs.svh */
`ifndef ETWS_DEFS_SVH
`define ETWS_DEFS_SVH

// clock rate
`define ETWS_MCLK_MHZ         125
`define ETWS_MCLK_PERIOD_NS   8
// self-timed write, longest time in ms
`define ETWS_TWR_MS           10
`define ETWS_TWR_CYCLES       (`ETWS_TWR_MS * 1000 * `ETWS_MCLK_MHZ)
// output hold after the clock falls, least time in ns (rounded up)
`define ETWS_THOLD_NS         300
`define ETWS_THOLD_CYCLES \
  ((`ETWS_THOLD_NS + `ETWS_MCLK_PERIOD_NS - 1) / `ETWS_MCLK_PERIOD_NS)
// page buffer depth
`define ETWS_PAGE_BYTES       16
// control byte layout
`define ETWS_CTRL_LEAD_VAL    1'h1
`define ETWS_BYTE_BITS        4'h8
`define ETWS_ADDR_BITS        11
`define ETWS_BLOCK_LSB        8

`endif

/* rtl/etws_pkg.sv */
package etws_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } etws_state_t;

  typedef enum logic [1:0] {
    ROLE_CTRL,
    ROLE_WADDR,
    ROLE_WDATA
  } etws_role_t;

  // control byte as it arrives, first bit in the msb
  typedef struct packed {
    logic       lead;
    logic       cs_high;
    logic       cs_mid;
    logic       cs_low;
    logic [2:0] block;
    logic       rd;
  } etws_ctrl_t;

  // handed to the programming logic at the start of a write cycle
  typedef struct packed {
    logic [10:0] addr;
    logic [4:0]  count;
  } etws_prog_t;

endpackage

/* rtl/etws_sync.sv */
`timescale 1ns/100ps
module etws_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // etws_sync

/* rtl/etws_front_end.sv */
`timescale 1ns/100ps
`include "etws_defs.svh"
// Overview of operation
// [RULE1] master drives clock, starts, stops; device slave
// [RULE2] master starts only when bus idle
// [RULE3] data change while clock high is start/stop
// [RULE4] data falling, clock high: start
// [RULE5] data rising, clock high: stop
// [RULE6] every command opens with start
// [RULE7] every operation closes with stop
// [RULE8] one bit per clock, sampled high
// [RULE9] keep latest sixteen written bytes, overwrite oldest
// [RULE10] addressed receiver acknowledges every byte
// [RULE11] master gives ninth clock for acknowledge
// [RULE12] acknowledge holds data low through high phase
// [RULE13] no acknowledge while programming runs
// [RULE14] master ends read by withholding acknowledge
// [RULE15] on missing acknowledge, release data line
// [RULE16] first byte after start is control
// [RULE17] control bits two-four match select pins
// [RULE18] middle select bit matches inverted pin
// [RULE19] next three bits pick block, address msbs
// [RULE20] last control bit: one read, zero write
// [RULE21] after start, match address, pick direction
// [RULE22] byte after write control loads address pointer
// [RULE23] stop after write starts timed programming
module etws_front_end #(
  parameter int unsigned WRITE_CYCLES = `ETWS_TWR_CYCLES,
  parameter int unsigned HOLD_CYCLES  = `ETWS_THOLD_CYCLES,
  parameter int unsigned PAGE_BYTES   = `ETWS_PAGE_BYTES
) (
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe_n,
  input  wire logic                      chip_select_pin_low,
  input  wire logic                      chip_select_pin_mid_inverted,
  input  wire logic                      chip_select_pin_high,
  output logic                           rd_req,
  output logic [`ETWS_ADDR_BITS-1:0]     rd_addr,
  input  wire logic [7:0]                rd_data,
  output logic                           prog_start,
  output etws_pkg::etws_prog_t           prog_info,
  output logic                           busy,
  input  wire logic [$clog2(PAGE_BYTES)-1:0] page_rd_idx,
  output logic [7:0]                     page_rd_data
);

  localparam int unsigned IW = $clog2(PAGE_BYTES);
  localparam int unsigned BW = $clog2(WRITE_CYCLES + 1);
  localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
  localparam int unsigned CW = $clog2(PAGE_BYTES + 1);

  logic [4:0]              pins_s;
  logic                    scl_s;
  logic                    sda_s;
  logic                    cs_low_s;
  logic                    cs_mid_s;
  logic                    cs_high_s;
  logic                    scl_prev_q;
  logic                    sda_prev_q;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_det;
  logic                    stop_det;
  etws_pkg::etws_state_t   state_q;
  etws_pkg::etws_role_t    role_q;
  logic [3:0]              bit_cnt_q;
  logic                    rd_mode_q;
  logic                    mack_q;
  logic [7:0]              rx_q;
  logic [7:0]              tx_q;
  etws_pkg::etws_ctrl_t    ctrl;
  logic                    byte_done;
  logic                    tx_done;
  logic                    addr_match;
  logic                    ctrl_ok;
  logic [`ETWS_ADDR_BITS-1:0] addr_q;
  logic [`ETWS_ADDR_BITS-1:0] wr_base_q;
  logic [7:0]              page_q [PAGE_BYTES];
  logic [CW-1:0]           wr_cnt_q;
  logic                    prog_go;
  logic [BW-1:0]           busy_cnt_q;
  logic [HW-1:0]           hold_cnt_q;
  logic                    want_low;
  logic                    rd_req_q;
  logic                    prog_start_q;
  etws_pkg::etws_prog_t    prog_info_q;
  logic [7:0]              page_rd_data_q;
  logic                    oe_n_q;

  etws_sync #(
    .WIDTH (5)
  ) u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in ({scl_in, sda_in, chip_select_pin_low,
                chip_select_pin_mid_inverted, chip_select_pin_high}),
    .sync_out (pins_s)
  );

  assign scl_s     = pins_s[4];
  assign sda_s     = pins_s[3];
  assign cs_low_s  = pins_s[2];
  assign cs_mid_s  = pins_s[1];
  assign cs_high_s = pins_s[0];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scl_prev_q <= 1'h1;
      sda_prev_q <= 1'h1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_prev_q; // [RULE8]
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s; // [RULE3] [RULE4]
  assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s; // [RULE3] [RULE5]

  assign ctrl      = etws_pkg::etws_ctrl_t'(rx_q);
  assign byte_done = (state_q == etws_pkg::ST_RX) && scl_fall
                     && (bit_cnt_q == `ETWS_BYTE_BITS);
  assign tx_done   = (state_q == etws_pkg::ST_TX) && scl_fall
                     && (bit_cnt_q == `ETWS_BYTE_BITS);

  // no answer at all while programming, own address included
  assign addr_match = (ctrl.lead == `ETWS_CTRL_LEAD_VAL) // [RULE16]
                      && (ctrl.cs_high == cs_high_s) // [RULE17]
                      && (ctrl.cs_mid == ~cs_mid_s) // [RULE18]
                      && (ctrl.cs_low == cs_low_s)
                      && !busy; // [RULE13]
  assign ctrl_ok   = byte_done && (role_q == etws_pkg::ROLE_CTRL) && addr_match; // [RULE21]

  // byte sequencing; start wins over anything in flight
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= etws_pkg::ST_IDLE;
      role_q    <= etws_pkg::ROLE_CTRL;
      bit_cnt_q <= 4'h0;
      rd_mode_q <= 1'h0;
      mack_q    <= 1'h0;
    end else if (start_det) begin
      state_q   <= etws_pkg::ST_RX; // [RULE21]
      role_q    <= etws_pkg::ROLE_CTRL; // [RULE16]
      bit_cnt_q <= 4'h0;
      rd_mode_q <= 1'h0;
    end else if (stop_det) begin
      state_q   <= etws_pkg::ST_IDLE;
    end else begin
      case (state_q)
        etws_pkg::ST_RX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            bit_cnt_q <= 4'h0;
            if (role_q != etws_pkg::ROLE_CTRL || addr_match) begin
              state_q <= etws_pkg::ST_ACK; // [RULE10]
            end else begin
              state_q <= etws_pkg::ST_IDLE;
            end
            if (role_q == etws_pkg::ROLE_CTRL) begin
              rd_mode_q <= ctrl.rd; // [RULE20]
            end
          end
        end
        etws_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (rd_mode_q) begin
              state_q <= etws_pkg::ST_TX;
            end else begin
              state_q <= etws_pkg::ST_RX;
              role_q  <= (role_q == etws_pkg::ROLE_CTRL) ? etws_pkg::ROLE_WADDR
                                                         : etws_pkg::ROLE_WDATA;
            end
          end
        end
        etws_pkg::ST_TX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (tx_done) begin
            bit_cnt_q <= 4'h0;
            state_q   <= etws_pkg::ST_MACK;
          end
        end
        etws_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_s;
          end else if (scl_fall) begin
            // missing acknowledge ends the read, line stays released
            state_q <= mack_q ? etws_pkg::ST_TX : etws_pkg::ST_IDLE; // [RULE15]
          end
        end
        default: begin
          state_q <= etws_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_q <= 8'h00;
    end else if (state_q == etws_pkg::ST_RX && scl_rise) begin
      rx_q <= {rx_q[6:0], sda_s}; // [RULE8]
    end
  end

  // next read byte asked for at control accept or master acknowledge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_req_q <= 1'h0;
    end else begin
      rd_req_q <= (ctrl_ok && ctrl.rd)
                  || (state_q == etws_pkg::ST_MACK && scl_fall && mack_q
                      && !start_det && !stop_det);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_q <= 8'hFF;
    end else if (rd_req_q) begin
      tx_q <= rd_data;
    end else if (state_q == etws_pkg::ST_TX && scl_fall && bit_cnt_q != 4'h0) begin
      tx_q <= {tx_q[6:0], 1'h1};
    end
  end

  // address pointer: block from control, word from first write byte
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q    <= '0;
      wr_base_q <= '0;
    end else if (ctrl_ok) begin
      addr_q[`ETWS_ADDR_BITS-1:`ETWS_BLOCK_LSB] <= ctrl.block; // [RULE19]
    end else if (byte_done && role_q == etws_pkg::ROLE_WADDR) begin
      addr_q[`ETWS_BLOCK_LSB-1:0]    <= rx_q; // [RULE22]
      wr_base_q[`ETWS_ADDR_BITS-1:0] <= {addr_q[`ETWS_ADDR_BITS-1:`ETWS_BLOCK_LSB], rx_q};
    end else if (byte_done && role_q == etws_pkg::ROLE_WDATA) begin
      // only the page bits move, upper address stays put
      addr_q[IW-1:0] <= addr_q[IW-1:0] + IW'(1); // [RULE9]
    end else if (tx_done) begin
      addr_q <= addr_q + `ETWS_ADDR_BITS'(1);
    end
  end

  // page buffer rolls over, so the latest bytes overwrite the oldest
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        page_q[i] <= 8'h00;
      end
    end else if (byte_done && role_q == etws_pkg::ROLE_WDATA) begin
      page_q[addr_q[IW-1:0]] <= rx_q; // [RULE9]
    end
  end

  // a repeated start drops the pending page, as a random read needs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_cnt_q <= '0;
    end else if (start_det || stop_det) begin
      wr_cnt_q <= '0;
    end else if (byte_done && role_q == etws_pkg::ROLE_WDATA
                 && wr_cnt_q != CW'(PAGE_BYTES)) begin
      wr_cnt_q <= wr_cnt_q + CW'(1);
    end
  end

  assign prog_go = stop_det && !rd_mode_q && (wr_cnt_q != '0)
                   && (state_q != etws_pkg::ST_IDLE); // [RULE23]

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prog_start_q <= 1'h0;
      prog_info_q  <= '0;
    end else begin
      prog_start_q <= prog_go;
      if (prog_go) begin
        prog_info_q.addr  <= wr_base_q;
        prog_info_q.count <= 5'(wr_cnt_q);
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_q <= '0;
    end else if (prog_go) begin
      busy_cnt_q <= BW'(WRITE_CYCLES); // [RULE23]
    end else if (busy_cnt_q != '0) begin
      busy_cnt_q <= busy_cnt_q - BW'(1);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      page_rd_data_q <= 8'h00;
    end else begin
      page_rd_data_q <= page_q[page_rd_idx];
    end
  end

  always_comb begin
    want_low = 1'h0;
    case (state_q)
      etws_pkg::ST_ACK: want_low = 1'h1; // [RULE12]
      etws_pkg::ST_TX:  want_low = rd_req_q ? ~rd_data[7] : ~tx_q[7]; // byte may still be loading
      default:          want_low = 1'h0;
    endcase
  end

  // data only changes a hold time after the clock falls, so our own
  // edge is never seen as a start or stop
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt_q <= '0;
    end else if (scl_fall) begin
      hold_cnt_q <= HW'(HOLD_CYCLES); // [RULE8]
    end else if (hold_cnt_q != '0) begin
      hold_cnt_q <= hold_cnt_q - HW'(1);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      oe_n_q <= 1'h1;
    end else if (state_q == etws_pkg::ST_IDLE || start_det || stop_det) begin
      oe_n_q <= 1'h1; // [RULE15]
    end else if (hold_cnt_q == HW'(1)) begin
      oe_n_q <= ~want_low; // [RULE12]
    end
  end

  assign sda_out      = 1'h0;
  assign sda_oe_n     = oe_n_q;
  assign rd_req       = rd_req_q;
  assign rd_addr      = addr_q;
  assign prog_start   = prog_start_q;
  assign prog_info    = prog_info_q;
  assign busy         = (busy_cnt_q != '0);
  assign page_rd_data = page_rd_data_q;

endmodule // etws_front_end

/* testbench/etws_front_end_asserts.sv */
`timescale 1ns/100ps
module etws_front_end_asserts #(
  parameter int unsigned WRITE_CYCLES = 200
) (
  input wire logic                 mclk,
  input wire logic                 reset_n,
  input wire logic                 scl_in,
  input wire logic                 sda_in,
  input wire logic                 sda_out,
  input wire logic                 sda_oe_n,
  input wire logic                 rd_req,
  input wire logic                 prog_start,
  input wire etws_pkg::etws_prog_t prog_info,
  input wire logic                 busy
);
  int unsigned busy_cnt_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy ? busy_cnt_q + 1 : 0;
    end
  end

  sequence start_seq;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence stop_seq;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  sequence pull_seq;
    $fell(sda_oe_n);
  endsequence

  AST_OPEN_DRAIN: assert property (sda_out == 1'h0)
    else $error("data pin driven high");
  AST_PULL_SCL_LOW: assert property (pull_seq |-> !scl_in)
    else $error("pull began with clock high");
  AST_ACK_HOLD: assert property (pull_seq |-> !sda_oe_n [*4])
    else $error("pull too short");
  AST_START_RELEASE: assert property (start_seq |-> ##[0:4] sda_oe_n [*8])
    else $error("data held after start");
  AST_STOP_RELEASE: assert property (stop_seq |-> sda_oe_n [*8])
    else $error("data held after stop");
  AST_BUSY_BLOCKS: assert property (busy |-> sda_oe_n)
    else $error("pull while busy");
  AST_PROG_BUSY: assert property (prog_start |=> busy && !prog_start)
    else $error("write start not followed by busy");
  AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt_q == WRITE_CYCLES)
    else $error("busy length wrong");
  AST_BUSY_BOUND: assert property (busy |-> busy_cnt_q < WRITE_CYCLES)
    else $error("busy too long");
  AST_PROG_COUNT: assert property (prog_start |-> prog_info.count inside {[5'h01:5'h10]})
    else $error("page count out of range");
  AST_RDREQ_PULSE: assert property (rd_req |=> !rd_req)
    else $error("read request longer than a cycle");
endmodule // etws_front_end_asserts

bind etws_front_end etws_front_end_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) i_asserts (
  .mclk(mclk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .rd_req(rd_req), .prog_start(prog_start), .prog_info(prog_info),
  .busy(busy));

/* testbench/etws_bus_master.sv */
`timescale 1ns/100ps
module etws_bus_master (
  input  wire logic mclk,
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda_m
);
  // fast 6 gives a 64 ns period; slow stretches only the low phase
  int unsigned low_cyc = 6;

  initial begin
    scl   = 1'h1;
    sda_m = 1'h1;
  end

  task automatic bit_x(input logic b, output logic r);
    @(posedge mclk) scl <= 1'h0;
    repeat (2) @(posedge mclk);
    sda_m <= b;
    repeat (low_cyc - 2) @(posedge mclk);
    scl <= 1'h1;
    @(posedge mclk);
    r = sda_bus;
  endtask

  task automatic start(input logic rep);
    logic r;
    if (rep) begin
      bit_x(1'h1, r);
      repeat (2) @(posedge mclk);
    end
    @(posedge mclk) sda_m <= 1'h0;
    repeat (4) @(posedge mclk);
  endtask

  task automatic stop();
    @(posedge mclk) scl <= 1'h0;
    repeat (2) @(posedge mclk);
    sda_m <= 1'h0;
    repeat (low_cyc) @(posedge mclk);
    scl <= 1'h1;
    repeat (4) @(posedge mclk);
    sda_m <= 1'h1;
    repeat (8) @(posedge mclk);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'h1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'h1, d[i]);
    bit_x(~mack, r);
  endtask
endmodule // etws_bus_master

/* testbench/etws_front_end_tb.sv */
`timescale 1ns/100ps
module etws_front_end_tb;
  logic                 mclk = 1'h0;
  logic                 reset_n = 1'h0;
  logic                 scl, sda_m, sda_in, sda_out, sda_oe_n, rd_req, prog_start, busy;
  logic [2:0]           pins;
  logic [10:0]          rd_addr, cap_addr;
  logic [7:0]           rd_data, page_rd_data, cap_data;
  logic [3:0]           page_rd_idx;
  etws_pkg::etws_prog_t prog_info, pi;
  logic [7:0]           exp_pg [16];
  int                   fail_count = 0;
  int                   n_compared = 0;
  int                   n_prog = 0;
  int                   cyc = 0;

  always #4 mclk = ~mclk;
  // open drain with pull-up
  assign sda_in = sda_m & (sda_oe_n | sda_out);

  etws_front_end #(.WRITE_CYCLES(200), .HOLD_CYCLES(1)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .chip_select_pin_low(pins[0]),
    .chip_select_pin_mid_inverted(pins[1]), .chip_select_pin_high(pins[2]),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .prog_start(prog_start),
    .prog_info(prog_info), .busy(busy), .page_rd_idx(page_rd_idx),
    .page_rd_data(page_rd_data));
  etws_bus_master i_mst (.mclk(mclk), .sda_bus(sda_in), .scl(scl), .sda_m(sda_m));

  always @(posedge mclk) begin
    rd_data <= 8'($urandom);
    if (rd_req === 1'h1) begin
      cap_addr <= rd_addr;
      cap_data <= rd_data;
    end
    if (prog_start === 1'h1) begin
      n_prog <= n_prog + 1;
      pi     <= prog_info;
    end
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fail_count++;
      $display("ERROR %0t timeout", $time);
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp, input string m);
    chk({15'h0000, got}, {15'h0000, exp}, m);
  endtask

  function automatic logic [7:0] ctrl_f(input logic [2:0] b, input logic rd);
    return {1'h1, pins[2], ~pins[1], pins[0], b, rd};
  endfunction

  task automatic wr_page(input logic [2:0] b, input logic [7:0] w, input int n);
    logic       a;
    logic [7:0] d;
    i_mst.start(1'h0);
    i_mst.wbyte(ctrl_f(b, 1'h0), a);
    chk_b(a, 1'h1, "ctrl ack");
    i_mst.wbyte(w, a);
    chk_b(a, 1'h1, "addr ack");
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      exp_pg[4'(w + 8'(i))] = d;
      i_mst.wbyte(d, a);
      chk_b(a, 1'h1, "data ack");
    end
  endtask

  initial begin
    logic       a;
    logic [2:0] b;
    logic [7:0] w, d;
    int         n, m, pc;
    void'($urandom(49));
    pins        <= 3'h0;
    page_rd_idx <= 4'h0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (4) @(posedge mclk);
    chk({sda_oe_n, busy, prog_start, rd_req, 12'h000}, 16'h8000, "reset outputs");
    for (int p = 0; p < 8; p++) begin
      pins <= 3'(p);
      i_mst.low_cyc = p[0] ? 14 : 6;
      repeat (4) @(posedge mclk);
      for (int k = 0; k < 4; k++) begin
        i_mst.start(1'h0);
        i_mst.wbyte(ctrl_f(3'(k), 1'h0) ^ (8'h80 >> k), a);
        chk_b(a, 1'h0, "refused ctrl");
        i_mst.stop();
      end
      b  = (p == 2) ? 3'h7 : 3'($urandom);
      w  = (p == 2) ? 8'hFF : 8'($urandom);
      n  = (p == 0) ? 1 : (p == 1) ? 20 : 1 + $urandom_range(15);
      m  = (n > 16) ? 16 : n;
      pc = n_prog;
      wr_page(b, w, n);
      i_mst.stop();
      chk(16'(n_prog - pc), 16'h0001, "prog starts");
      chk(16'(pi), {b, w, 5'(m)}, "prog info");
      chk_b(busy, 1'h1, "busy");
      i_mst.start(1'h0);
      i_mst.wbyte(ctrl_f(b, 1'h0), a);
      chk_b(a, 1'h0, "busy nack");
      i_mst.stop();
      for (int k = 0; k < m; k++) begin
        @(posedge mclk) page_rd_idx <= 4'(w + 8'(k));
        repeat (2) @(posedge mclk);
        chk(16'(page_rd_data), 16'(exp_pg[4'(w + 8'(k))]), "page data");
      end
      for (int t = 0; t < 8 && a !== 1'h1; t++) begin
        i_mst.start(1'h0);
        i_mst.wbyte(ctrl_f(b, 1'h0), a);
        i_mst.stop();
      end
      chk_b(a, 1'h1, "poll ack");
      wr_page(b, w, 0);
      i_mst.start(1'h1);
      i_mst.wbyte(ctrl_f(b, 1'h1), a);
      chk_b(a, 1'h1, "read ctrl ack");
      n = 1 + $urandom_range(2);
      for (int i = 0; i < n; i++) begin
        i_mst.rbyte(i < n - 1, d);
        chk(16'(cap_addr), 16'(11'({b, w} + 11'(i))), "read addr");
        chk(16'(d), 16'(cap_data), "read data");
      end
      chk_b(sda_in, 1'h1, "released");
      i_mst.stop();
      $display("test pins %0d done", p);
    end
    end_sim();
  end
endmodule // etws_front_end_tb
